// ### hdl/src_regs.sv
/*
  Control and status registers for two switching converters and the
  pll linear regulator, plus sticky event status with mask.
  Assumes analogue inputs are already synchronous to clk_sys_i and that
  mode pins are stable around reset release.
*/
// Functional notes
// - power-good threshold bits 25:24, reset 2
// - bit 16 clears converter errors, not self-clearing
// - analog converter current limit bits 14:13
// - analog converter clock select bits 9:8, reset 1
// - core converter current limit bits 6:5
// - core converter clock select bits 1:0, reset 1
// - status register live, read-only
// - status bit 24 oscillator stable
// - bit 19 pll rail good, bit 16 core
// - bits 9/8 current limiting, analog/core
// - bits 1/0 soft-start, analog/core
// - core level seven bits, 0.60V plus 10mV/code
// - level reset values come from mode pins
// - pll level three bits, 0.6V plus 100mV/code
`timescale 1ns/1ps
module src_regs (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // register port
  input wire logic [src_pkg::ADDR_W-1:0] addr_i,
  input wire logic [src_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [src_pkg::DATA_W-1:0] rdata_o,
  // mode pin straps for level reset values
  input wire logic [src_pkg::CORE_LVL_W-1:0] strap_core_lvl_i,
  input wire logic [src_pkg::PLL_LVL_W-1:0] strap_pll_lvl_i,
  // live analogue status
  input wire logic osc_stable_i,
  input wire logic pll_rail_good_i,
  input wire logic core_rail_good_i,
  input wire logic analog_climit_i,
  input wire logic core_climit_i,
  input wire logic analog_softstart_i,
  input wire logic core_softstart_i,
  // analogue controls
  output logic [1:0] pgood_thresh_o,
  output logic conv_err_clear_o,
  output logic [1:0] analog_ilimit_o,
  output logic [1:0] analog_clk_sel_o,
  output logic [1:0] core_ilimit_o,
  output logic [1:0] core_clk_sel_o,
  output logic [src_pkg::CORE_LVL_W-1:0] core_rail_level_o,
  output logic [src_pkg::PLL_LVL_W-1:0] pll_rail_level_o,
  // interrupt
  output logic irq_o
);

  typedef struct packed {
    logic [1:0] pg;
    logic errclr;
    logic [1:0] alim;
    logic [1:0] aclk;
    logic [1:0] clim;
    logic [1:0] cclk;
    logic [src_pkg::CORE_LVL_W-1:0] core_lvl;
    logic [src_pkg::PLL_LVL_W-1:0] pll_lvl;
    logic strap_done;
    logic [src_pkg::EV_W-1:0] ev_stat;
    logic [src_pkg::EV_W-1:0] ev_mask;
    logic [6:0] live_q;
    logic [src_pkg::DATA_W-1:0] rdata;
  } src_state_t;

  src_state_t st_r;
  src_state_t st_nxt;

  logic [6:0] live;
  logic [src_pkg::DATA_W-1:0] status_word;
  logic [src_pkg::EV_W-1:0] ev_set;

  function automatic logic [src_pkg::DATA_W-1:0] fld2(
    input logic [1:0] v, input int lo);
    logic [src_pkg::DATA_W-1:0] w;
    w = '0;
    w[lo +: 2] = v;
    return w;
  endfunction

  function automatic logic [src_pkg::DATA_W-1:0] bit1(
    input logic v, input int pos);
    logic [src_pkg::DATA_W-1:0] w;
    w = '0;
    w[pos] = v;
    return w;
  endfunction

  // order: osc, pllgood, coregood, alim, clim, ass, css
  assign live = {osc_stable_i, pll_rail_good_i, core_rail_good_i,
                 analog_climit_i, core_climit_i, analog_softstart_i,
                 core_softstart_i};

  // status built straight from the inputs, no history kept
  assign status_word =
      bit1(osc_stable_i, src_pkg::ST_OSC)
    | bit1(pll_rail_good_i, src_pkg::ST_PLL_GOOD)
    | bit1(core_rail_good_i, src_pkg::ST_CORE_GOOD)
    | bit1(analog_climit_i, src_pkg::ST_ALIM)
    | bit1(core_climit_i, src_pkg::ST_CLIM)
    | bit1(analog_softstart_i, src_pkg::ST_ASS)
    | bit1(core_softstart_i, src_pkg::ST_CSS);

  // events: falling good levels, rising current limit, soft-start ends
  always_comb begin
    ev_set = '0;
    ev_set[src_pkg::EV_OSC_LOST] = st_r.live_q[6] & ~live[6];
    ev_set[src_pkg::EV_PLL_BAD] = st_r.live_q[5] & ~live[5];
    ev_set[src_pkg::EV_CORE_BAD] = st_r.live_q[4] & ~live[4];
    ev_set[src_pkg::EV_ALIM] = ~st_r.live_q[3] & live[3];
    ev_set[src_pkg::EV_CLIM] = ~st_r.live_q[2] & live[2];
    ev_set[src_pkg::EV_SS_DONE] = (st_r.live_q[1] & ~live[1])
                                | (st_r.live_q[0] & ~live[0]);
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.live_q = live;
    st_nxt.rdata = '0;
    // straps are caught on the first clock after reset release
    if (!st_r.strap_done) begin
      st_nxt.core_lvl = strap_core_lvl_i;
      st_nxt.pll_lvl = strap_pll_lvl_i;
      st_nxt.strap_done = 1'b1;
    end
    // clear by writing one; a new event in the same cycle wins
    st_nxt.ev_stat = st_r.ev_stat;
    if (wr_i && addr_i == src_pkg::OFS_IRQ_STAT) begin
      st_nxt.ev_stat = st_r.ev_stat & ~wdata_i[src_pkg::EV_W-1:0];
    end
    st_nxt.ev_stat = st_nxt.ev_stat | ev_set;
    // only defined fields are stored
    if (wr_i) begin
      unique case (addr_i)
        src_pkg::OFS_CONV_CTRL: begin
          st_nxt.pg = wdata_i[src_pkg::PG_LO +: 2];
          st_nxt.errclr = wdata_i[src_pkg::ERRCLR_BIT];
          st_nxt.alim = wdata_i[src_pkg::ALIM_LO +: 2];
          st_nxt.aclk = wdata_i[src_pkg::ACLK_LO +: 2];
          st_nxt.clim = wdata_i[src_pkg::CLIM_LO +: 2];
          st_nxt.cclk = wdata_i[src_pkg::CCLK_LO +: 2];
        end
        src_pkg::OFS_CORE_LVL: begin
          st_nxt.core_lvl = wdata_i[src_pkg::CORE_LVL_W-1:0];
          st_nxt.strap_done = 1'b1;
        end
        src_pkg::OFS_PLL_LVL: begin
          st_nxt.pll_lvl = wdata_i[src_pkg::PLL_LVL_W-1:0];
          st_nxt.strap_done = 1'b1;
        end
        src_pkg::OFS_IRQ_MASK: begin
          st_nxt.ev_mask = wdata_i[src_pkg::EV_W-1:0];
        end
        default: begin
        end
      endcase
    end
    // read data is valid one cycle after the strobe; unmapped read zero
    if (rd_i) begin
      unique case (addr_i)
        src_pkg::OFS_CONV_CTRL: begin
          st_nxt.rdata = fld2(st_r.pg, src_pkg::PG_LO)
            | bit1(st_r.errclr, src_pkg::ERRCLR_BIT)
            | fld2(st_r.alim, src_pkg::ALIM_LO)
            | fld2(st_r.aclk, src_pkg::ACLK_LO)
            | fld2(st_r.clim, src_pkg::CLIM_LO)
            | fld2(st_r.cclk, src_pkg::CCLK_LO);
        end
        src_pkg::OFS_STATUS: begin
          st_nxt.rdata = status_word;
        end
        src_pkg::OFS_CORE_LVL: begin
          st_nxt.rdata[src_pkg::CORE_LVL_W-1:0] = st_r.core_lvl;
        end
        src_pkg::OFS_PLL_LVL: begin
          st_nxt.rdata[src_pkg::PLL_LVL_W-1:0] = st_r.pll_lvl;
        end
        src_pkg::OFS_IRQ_STAT: begin
          st_nxt.rdata[src_pkg::EV_W-1:0] = st_r.ev_stat;
        end
        src_pkg::OFS_IRQ_MASK: begin
          st_nxt.rdata[src_pkg::EV_W-1:0] = st_r.ev_mask;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r <= '0;
      st_r.pg <= src_pkg::PG_RST;
      st_r.alim <= src_pkg::ALIM_RST;
      st_r.aclk <= src_pkg::ACLK_RST;
      st_r.clim <= src_pkg::CLIM_RST;
      st_r.cclk <= src_pkg::CCLK_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // error clear stays asserted while the bit is one
  assign conv_err_clear_o = st_r.errclr;
  assign pgood_thresh_o = st_r.pg;
  assign analog_ilimit_o = st_r.alim;
  assign analog_clk_sel_o = st_r.aclk;
  assign core_ilimit_o = st_r.clim;
  assign core_clk_sel_o = st_r.cclk;
  assign core_rail_level_o = st_r.core_lvl;
  assign pll_rail_level_o = st_r.pll_lvl;
  assign rdata_o = st_r.rdata;
  assign irq_o = |(st_r.ev_stat & st_r.ev_mask);

endmodule

// ### hdl/src_pkg.sv
/*
  Package for the supply regulator control register bank: register
  offsets, field positions, reset values and interrupt layout.
  Assumes a plain word-addressed register port with byte addresses.
*/
package src_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] OFS_CONV_CTRL = 8'h2C;
  localparam logic [7:0] OFS_STATUS = 8'h30;
  localparam logic [7:0] OFS_CORE_LVL = 8'h34;
  localparam logic [7:0] OFS_PLL_LVL = 8'h40;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h50;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h54;

  // converter_control fields
  localparam int PG_LO = 24;
  localparam int ERRCLR_BIT = 16;
  localparam int ALIM_LO = 13;
  localparam int ACLK_LO = 8;
  localparam int CLIM_LO = 5;
  localparam int CCLK_LO = 0;

  localparam logic [1:0] PG_RST = 2'h2;
  localparam logic [1:0] ALIM_RST = 2'h0;
  localparam logic [1:0] ACLK_RST = 2'h1;
  localparam logic [1:0] CLIM_RST = 2'h0;
  localparam logic [1:0] CCLK_RST = 2'h1;

  // supply_status fields
  localparam int ST_OSC = 24;
  localparam int ST_PLL_GOOD = 19;
  localparam int ST_CORE_GOOD = 16;
  localparam int ST_ALIM = 9;
  localparam int ST_CLIM = 8;
  localparam int ST_ASS = 1;
  localparam int ST_CSS = 0;

  // level widths
  localparam int CORE_LVL_W = 7;
  localparam int PLL_LVL_W = 3;

  // interrupt event bits (same layout in status and mask)
  localparam int EV_W = 6;
  localparam int EV_OSC_LOST = 0;
  localparam int EV_PLL_BAD = 1;
  localparam int EV_CORE_BAD = 2;
  localparam int EV_ALIM = 3;
  localparam int EV_CLIM = 4;
  localparam int EV_SS_DONE = 5;

endpackage

// ### sim/src_regs_sva.sv
/* checker for src_regs: bus, status and control relations.
   bound from the bench; sees only the ports of src_regs */
`timescale 1ns/1ps
module src_regs_sva (
  // clock, reset and register port
  input logic clk_sys_i, rstn_i, wr_i, rd_i,
  input logic [src_pkg::ADDR_W-1:0] addr_i,
  input logic [src_pkg::DATA_W-1:0] wdata_i, rdata_o,
  // live status
  input logic osc_stable_i, pll_rail_good_i, core_rail_good_i,
  input logic analog_climit_i, core_climit_i,
  input logic analog_softstart_i, core_softstart_i,
  // controls
  input logic [1:0] pgood_thresh_o, analog_ilimit_o, analog_clk_sel_o,
  input logic [1:0] core_ilimit_o, core_clk_sel_o,
  input logic conv_err_clear_o,
  input logic [src_pkg::CORE_LVL_W-1:0] core_rail_level_o
);
  logic [10:0] ctl, wsel;
  logic rs, cw;
  logic [6:0] wlvl;
  assign wlvl = wdata_i[6:0];
  assign ctl = {pgood_thresh_o, conv_err_clear_o, analog_ilimit_o,
    analog_clk_sel_o, core_ilimit_o, core_clk_sel_o};
  assign wsel = {wdata_i[25:24], wdata_i[16], wdata_i[14:13],
    wdata_i[9:8], wdata_i[6:5], wdata_i[1:0]};
  assign rs = rd_i && addr_i == 8'h30;
  assign cw = wr_i && addr_i == 8'h2C;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  chk_rd_idle: assert property (!$past(rd_i) |-> rdata_o == '0)
    else $error("read data outside read cycle");
  chk_stat_osc: assert property (rs |=>
    rdata_o[24] == $past(osc_stable_i)) else $error("osc bit wrong");
  chk_stat_rails: assert property (rs |=>
    rdata_o[19] == $past(pll_rail_good_i) &&
    rdata_o[16] == $past(core_rail_good_i)) else $error("rail bits wrong");
  chk_stat_modes: assert property (rs |=>
    rdata_o[9] == $past(analog_climit_i) &&
    rdata_o[8] == $past(core_climit_i) &&
    rdata_o[1] == $past(analog_softstart_i) &&
    rdata_o[0] == $past(core_softstart_i))
    else $error("mode bits wrong");
  chk_stat_rsvd: assert property (rs |=>
    (rdata_o & 32'hFEF6FCFC) == '0) else $error("status reserved set");
  chk_ctrl_write: assert property (cw |=>
    ctl == $past(wsel)) else $error("control fields not written");
  chk_ctrl_hold: assert property (!cw |=> $stable(ctl))
    else $error("control changed without write");
  chk_core_level: assert property (wr_i && addr_i == 8'h34 |=>
    core_rail_level_o == $past(wlvl)) else $error("core level");
endmodule

// ### sim/tb_supply_regulator_control_regs.sv
/* bench for src_regs: drives the register port and the live status
   inputs, checks reads, control outputs, levels and the interrupt.
   assumes straps stay steady through reset */
`timescale 1ns/1ps
module tb_supply_regulator_control_regs;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic [6:0] st = 7'h00;
  logic [31:0] rdata_o;
  logic [1:0] pg, ail, acs, cil, ccs;
  logic ecl, irq_o;
  logic [6:0] core_lvl;
  logic [2:0] pll_lvl;
  int err_total = 0;
  int checks = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  src_regs DUT (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .strap_core_lvl_i(7'h2A), .strap_pll_lvl_i(3'h5),
    .osc_stable_i(st[6]), .pll_rail_good_i(st[5]),
    .core_rail_good_i(st[4]), .analog_climit_i(st[3]),
    .core_climit_i(st[2]), .analog_softstart_i(st[1]),
    .core_softstart_i(st[0]), .pgood_thresh_o(pg),
    .conv_err_clear_o(ecl), .analog_ilimit_o(ail),
    .analog_clk_sel_o(acs), .core_ilimit_o(cil), .core_clk_sel_o(ccs),
    .core_rail_level_o(core_lvl), .pll_rail_level_o(pll_lvl),
    .irq_o(irq_o));
  function automatic logic [31:0] ctl();
    return {21'h0, pg, ecl, ail, acs, cil, ccs};
  endfunction
  task automatic chk(input string n, input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
    #1;
  endtask
  task automatic rc(input string n, input logic [7:0] a,
                    input logic [31:0] exp);
    @(posedge clk_sys_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    chk(n, rdata_o, exp);
  endtask
  task automatic t_reset();
    rc("ctrl", 8'h2C, 32'h02000101);
    chk("ctl out", ctl(), 32'h411);
    rc("core lvl", 8'h34, 32'h2A);
    rc("pll lvl", 8'h40, 32'h5);
    rc("unmapped", 8'h10, 32'h0);
  endtask
  task automatic t_ctrl();
    logic [1:0] c;
    logic [31:0] w;
    wr(8'h2C, 32'hFFFFFFFF);
    repeat (4) @(posedge clk_sys_i);
    chk("ctl out", ctl(), 32'h7FF);
    rc("ctrl", 8'h2C, 32'h03016363);
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      w = {6'h0, c, 9'h0, c, 3'h0, c, 1'b0, c, 3'h0, c};
      wr(8'h2C, w);
      chk("ctl out", ctl(), {21'h0, c, 1'b0, c, c, c, c});
      rc("ctrl", 8'h2C, w);
    end
  endtask
  task automatic t_status();
    logic [6:0] s;
    logic [31:0] e;
    wr(8'h30, 32'hFFFFFFFF);
    for (int i = 0; i < 8; i++) begin
      s = 7'h01 << i;
      e = {7'h0, s[6], 4'h0, s[5], 2'h0, s[4], 6'h0, s[3], s[2],
        6'h0, s[1], s[0]};
      @(posedge clk_sys_i);
      st <= s;
      rc("status", 8'h30, e);
    end
  endtask
  task automatic t_level();
    logic [6:0] v;
    v = 7'h2A;
    // one code per microsecond keeps the rail slew within its limit
    while (v != 7'h46) begin
      v = v + 7'h01;
      wr(8'h34, {25'h1FFFFFF, v});
      repeat (100) @(posedge clk_sys_i);
    end
    rc("core lvl", 8'h34, 32'h46);
    chk("core out", {25'h0, core_lvl}, 32'h46);
    wr(8'h40, 32'hFFFFFFFE);
    wr(8'h40, 32'hFFFFFFFF);
    rc("pll lvl", 8'h40, 32'h7);
    wr(8'h40, 32'h3);
    chk("pll out", {29'h0, pll_lvl}, 32'h3);
  endtask
  // events sit on the climit inputs; two cycles cover the irq register
  task automatic t_irq();
    wr(8'h50, 32'hFF);
    wr(8'h54, 32'h10);
    chk("irq", {31'h0, irq_o}, 32'h0);
    @(posedge clk_sys_i);
    st <= 7'h04;
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk("irq", {31'h0, irq_o}, 32'h1);
    rc("ev stat", 8'h50, 32'h10);
    @(posedge clk_sys_i);
    st <= 7'h08;
    wr(8'h50, 32'h10);
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk("irq", {31'h0, irq_o}, 32'h0);
    rc("ev stat", 8'h50, 32'h08);
  endtask
  task automatic close_out();
    if (err_total == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    t_reset();
    t_ctrl();
    t_status();
    t_level();
    t_irq();
    close_out();
  end
  initial begin
    #100000;
    err_total++;
    close_out();
  end
endmodule
bind src_regs src_regs_sva chk (.*);
